// ---- verilog/timer_pkg.sv ----
// shared constants and carrier types for the dual 16-bit capture/compare timer
// assumes one 10 MHz clock and a byte-wide cpu i/o port in the same domain
package timer_pkg;

   // ---------------------------------------------------------------
   // register index map: addr[4] picks the timer, addr[3:0] the byte
   // ---------------------------------------------------------------
   localparam logic [3:0] REG_CTRL_B = 4'h0;
   localparam logic [3:0] REG_CNT_L  = 4'h1;
   localparam logic [3:0] REG_CNT_H  = 4'h2;
   localparam logic [3:0] REG_CMPA_L = 4'h3;
   localparam logic [3:0] REG_CMPA_H = 4'h4;
   localparam logic [3:0] REG_CMPB_L = 4'h5;
   localparam logic [3:0] REG_CMPB_H = 4'h6;
   localparam logic [3:0] REG_CAP_L  = 4'h7;
   localparam logic [3:0] REG_CAP_H  = 4'h8;
   localparam logic [2:0] BLOCK_BASE = 3'h0;

   // ---------------------------------------------------------------
   // control b layout
   // ---------------------------------------------------------------
   localparam int         BIT_FILTER = 7;
   localparam int         BIT_EDGE   = 6;
   localparam int         WGM_HI_MSB = 4;
   localparam int         WGM_HI_LSB = 3;
   localparam int         CS_MSB     = 2;
   localparam logic [7:0] CTRL_WMASK = 8'hDF;
   localparam logic [7:0] CTRL_RESET = 8'h00;

   // ---------------------------------------------------------------
   // clock select codes and prescaler taps
   // ---------------------------------------------------------------
   localparam logic [2:0] CS_STOP    = 3'h0;
   localparam logic [2:0] CS_DIV1    = 3'h1;
   localparam logic [2:0] CS_DIV8    = 3'h2;
   localparam logic [2:0] CS_DIV64   = 3'h3;
   localparam logic [2:0] CS_DIV256  = 3'h4;
   localparam logic [2:0] CS_DIV1024 = 3'h5;
   localparam logic [2:0] CS_ALT_LO  = 3'h6;
   localparam logic [2:0] CS_ALT_HI  = 3'h7;
   localparam logic [9:0] MASK_DIV8    = 10'h007;
   localparam logic [9:0] MASK_DIV16   = 10'h00F;
   localparam logic [9:0] MASK_DIV32   = 10'h01F;
   localparam logic [9:0] MASK_DIV64   = 10'h03F;
   localparam logic [9:0] MASK_DIV256  = 10'h0FF;
   localparam logic [9:0] MASK_DIV1024 = 10'h3FF;

   // ---------------------------------------------------------------
   // fixed tops and filter
   // ---------------------------------------------------------------
   localparam logic [15:0] TOP_FULL = 16'hFFFF;
   localparam logic [15:0] TOP_8    = 16'h00FF;
   localparam logic [15:0] TOP_9    = 16'h01FF;
   localparam logic [15:0] TOP_10   = 16'h03FF;
   localparam logic [3:0]  FILT_ONE  = 4'hF;
   localparam logic [3:0]  FILT_ZERO = 4'h0;

   // ---------------------------------------------------------------
   // carriers
   // ---------------------------------------------------------------
   typedef struct packed {
      logic       sync1;
      logic       sync2;
      logic [3:0] hist;
      logic       lvl;
      logic       prev;
   } cond_state_t;

   typedef struct packed {
      logic capture_flag_set; // capture or top-reach in capture-top modes
      logic match_a;
      logic match_b;
      logic at_top;
   } events_t;

   typedef struct packed {
      logic [7:0]  ctrl;
      logic [15:0] count;
      logic [15:0] cmp_a;
      logic [15:0] cmp_b;
      logic [15:0] cap;
      logic        block;
   } timer_regs_t;

   typedef struct packed {
      timer_regs_t [1:0] tmr;
      logic [7:0]        temp;
      logic [9:0]        presc;
      logic              ext_s1;
      logic              ext_s2;
      logic              ext_prev;
      logic [7:0]        rdata;
      events_t [1:0]     ev;
   } top_state_t;

endpackage

// ---- verilog/capture_conditioner.sv ----
// capture pin synchroniser, optional four-sample filter and edge detector
// assumes the pin is asynchronous to clk
module capture_conditioner
   import timer_pkg::*;
(
   input  wire logic clk,           // i/o clock
   input  wire logic rstn,          // async reset, active low
   input  wire logic pin,           // raw capture pin
   input  wire logic filter_enable, // four-sample filter on
   input  wire logic edge_select,   // 1 rising, 0 falling
   input  wire logic enable,        // low when capture is disconnected
   output logic      capture_event  // one-cycle trigger
);

   cond_state_t s;
   cond_state_t next_s;

   // ---------------------------------------------------------------
   // filter
   // ---------------------------------------------------------------
   // sync1 feeds sync2 only; the filter looks at sync2 and later
   always_comb begin
      next_s       = s;
      next_s.sync1 = pin;
      next_s.sync2 = s.sync1;
      next_s.hist  = {s.hist[2:0], s.sync2};
      if (!filter_enable) begin
         next_s.lvl = s.sync2;
      end else if (s.hist == FILT_ONE) begin
         next_s.lvl = 1'b1;
      end else if (s.hist == FILT_ZERO) begin
         next_s.lvl = 1'b0;
      end
      next_s.prev = s.lvl;
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   // edge on the conditioned level, polarity from the select bit
   assign capture_event = enable && (s.lvl != s.prev) && (s.lvl == edge_select);

   default clocking @(posedge clk); endclocking
   default disable iff (!rstn);

   filter_agree_a: assert property (
      filter_enable && $past(filter_enable) && $changed(s.lvl)
      |-> $past(s.hist) == {4{s.lvl}})
      else $error("filtered level changed without four equal samples");

   sequence held_high_filtered;
      filter_enable && $rose(s.sync2) ##1 (filter_enable && s.sync2) [*3];
   endsequence

   filter_delay_a: assert property (held_high_filtered |-> ##2 s.lvl)
      else $error("filtered level late after four samples");

   raw_delay_a: assert property (!filter_enable && $rose(s.sync2) |=> s.lvl)
      else $error("unfiltered level not one cycle after sync");

   edge_pick_a: assert property (
      capture_event |-> s.lvl == edge_select && $past(s.lvl) != s.lvl)
      else $error("capture on wrong edge");

endmodule // capture_conditioner

// ---- verilog/timer16_capture_compare_ctrl.sv ----
// two 16-bit timer/counters: clocking, counter, compare, capture and cpu bytes
// assumes a byte-wide cpu i/o port on clk; flag and waveform logic sit outside
//
// Operation
// - filter needs four equal samples to change
// - filtered capture arrives four cycles later
// - edge select: zero falling, one rising
// - trigger copies count into capture value
// - trigger also sets the capture flag
// - capture-as-top modes disconnect the capture input
// - clock select code zero stops, one to five divide
// - first timer codes six, seven count pin
// - second timer codes six, seven divide 16/32
// - pin counts even when driven as output
// - one shared high-byte latch for 16-bit access
// - count write blocks next-tick compare matches
// - compare values checked against count on each counter tick
// - four-bit mode field picks top; counting is upward only
// - capture-top modes flag on reaching top
module timer16_capture_compare_ctrl
   import timer_pkg::*;
(
   input  wire logic           clk,                 // i/o clock, 10 MHz
   input  wire logic           rstn,                // async reset, active low
   input  wire logic [7:0]     io_addr,             // register index
   input  wire logic [7:0]     io_wdata,            // write byte
   input  wire logic           io_wr,               // write strobe
   input  wire logic           io_rd,               // read strobe
   output logic      [7:0]     io_rdata,            // read byte, next cycle
   input  wire logic [1:0]     capture_input_pin,   // capture pins, per timer
   input  wire logic           external_count_pin,  // count pin, first timer
   input  wire logic [1:0][1:0] waveform_mode_lower, // low mode bits from control a
   output events_t   [1:0]     events               // per-timer event pulses
);

   top_state_t s;
   top_state_t next_s;
   logic [1:0] tick;
   logic [1:0] cap_event;
   logic [1:0] cap_enable;
   logic       ext_fall;
   logic       ext_rise;

   // ---------------------------------------------------------------
   // helpers
   // ---------------------------------------------------------------
   function automatic logic [3:0] mode_of(input logic [7:0] ctrl, input logic [1:0] low);
      mode_of = {ctrl[WGM_HI_MSB:WGM_HI_LSB], low};
   endfunction

   // modes whose top is the capture value
   function automatic logic cap_is_top(input logic [3:0] mode);
      cap_is_top = (mode == 4'h8) || (mode == 4'hA) || (mode == 4'hC) || (mode == 4'hE);
   endfunction

   // top value per mode; counting is upward only in this block
   function automatic logic [15:0] top_of(input logic [3:0]  mode,
                                          input logic [15:0] cmp_a,
                                          input logic [15:0] cap);
      case (mode)
         4'h1, 4'h5: top_of = TOP_8;
         4'h2, 4'h6: top_of = TOP_9;
         4'h3, 4'h7: top_of = TOP_10;
         4'h4, 4'h9, 4'hB, 4'hF: top_of = cmp_a;
         4'h8, 4'hA, 4'hC, 4'hE: top_of = cap;
         default: top_of = TOP_FULL;
      endcase
   endfunction

   function automatic logic tap(input logic [9:0] p, input logic [9:0] mask);
      tap = (p & mask) == mask;
   endfunction

   // count enable from the clock select code
   function automatic logic pick_tick(input logic [2:0] cs,
                                      input logic       first,
                                      input logic [9:0] p,
                                      input logic       fall,
                                      input logic       rise);
      case (cs)
         CS_STOP:    pick_tick = 1'b0;
         CS_DIV1:    pick_tick = 1'b1;
         CS_DIV8:    pick_tick = tap(p, MASK_DIV8);
         CS_DIV64:   pick_tick = tap(p, MASK_DIV64);
         CS_DIV256:  pick_tick = tap(p, MASK_DIV256);
         CS_DIV1024: pick_tick = tap(p, MASK_DIV1024);
         CS_ALT_LO:  pick_tick = first ? fall : tap(p, MASK_DIV16);
         CS_ALT_HI:  pick_tick = first ? rise : tap(p, MASK_DIV32);
         default:    pick_tick = 1'b0;
      endcase
   endfunction

   // ---------------------------------------------------------------
   // capture input conditioning
   // ---------------------------------------------------------------
   for (genvar g = 0; g < 2; g++) begin : g_cap
      capture_conditioner u_cond (
         .clk           (clk),
         .rstn          (rstn),
         .pin           (capture_input_pin[g]),
         .filter_enable (s.tmr[g].ctrl[BIT_FILTER]),
         .edge_select   (s.tmr[g].ctrl[BIT_EDGE]),
         .enable        (cap_enable[g]),
         .capture_event (cap_event[g])
      );
   end

   // ---------------------------------------------------------------
   // count pin edges and tick selection
   // ---------------------------------------------------------------
   // the pin is sampled as a plain input, so its port direction elsewhere
   // does not matter: software can drive it and still count
   assign ext_fall = s.ext_prev && !s.ext_s2;
   assign ext_rise = !s.ext_prev && s.ext_s2;

   always_comb begin
      for (int t = 0; t < 2; t++) begin
         tick[t] = pick_tick(s.tmr[t].ctrl[CS_MSB:0], t == 0, s.presc, ext_fall, ext_rise);
         cap_enable[t] = !cap_is_top(mode_of(s.tmr[t].ctrl, waveform_mode_lower[t]));
      end
   end

   // ---------------------------------------------------------------
   // next state: counters, compares, capture, then cpu access
   // ---------------------------------------------------------------
   // the cpu part comes last so a write wins over a same-cycle count
   always_comb begin
      logic        sel;
      logic [3:0]  off;
      logic [3:0]  mode;
      logic [15:0] top;
      logic        hit;
      sel      = io_addr[4];
      off      = io_addr[3:0];
      mode     = '0;
      top      = '0;
      hit      = io_addr[7:5] == BLOCK_BASE;
      next_s          = s;
      next_s.ev       = '0;
      next_s.presc    = 10'(s.presc + 10'h001);
      next_s.ext_s1   = external_count_pin;
      next_s.ext_s2   = s.ext_s1;
      next_s.ext_prev = s.ext_s2;

      for (int t = 0; t < 2; t++) begin
         mode = mode_of(s.tmr[t].ctrl, waveform_mode_lower[t]);
         top  = top_of(mode, s.tmr[t].cmp_a, s.tmr[t].cap);
         if (tick[t]) begin
            // a blocked tick still counts but reports no match
            next_s.ev[t].match_a = !s.tmr[t].block && s.tmr[t].count == s.tmr[t].cmp_a;
            next_s.ev[t].match_b = !s.tmr[t].block && s.tmr[t].count == s.tmr[t].cmp_b;
            next_s.tmr[t].block  = 1'b0;
            next_s.ev[t].at_top  = s.tmr[t].count == top;
            if (s.tmr[t].count == top) begin
               next_s.tmr[t].count = '0;
               if (cap_is_top(mode)) begin
                  next_s.ev[t].capture_flag_set = 1'b1;
               end
            end else begin
               next_s.tmr[t].count = 16'(s.tmr[t].count + 16'h0001);
            end
         end
         if (cap_event[t]) begin
            next_s.tmr[t].cap              = s.tmr[t].count;
            next_s.ev[t].capture_flag_set  = 1'b1;
         end
      end

      // byte writes: high bytes park in the shared latch
      if (io_wr && hit) begin
         case (off)
            REG_CTRL_B: next_s.tmr[sel].ctrl = io_wdata & CTRL_WMASK;
            REG_CNT_H, REG_CMPA_H, REG_CMPB_H, REG_CAP_H: next_s.temp = io_wdata;
            REG_CNT_L: begin
               next_s.tmr[sel].count = {s.temp, io_wdata};
               next_s.tmr[sel].block = 1'b1;
            end
            REG_CMPA_L: next_s.tmr[sel].cmp_a = {s.temp, io_wdata};
            REG_CMPB_L: next_s.tmr[sel].cmp_b = {s.temp, io_wdata};
            REG_CAP_L:  next_s.tmr[sel].cap   = {s.temp, io_wdata};
            default: ;
         endcase
      end

      // byte reads: a low read also loads its high byte into the latch
      if (io_rd) begin
         next_s.rdata = '0;
         if (hit) begin
            case (off)
               REG_CTRL_B: next_s.rdata = s.tmr[sel].ctrl;
               REG_CNT_L: begin
                  next_s.rdata = s.tmr[sel].count[7:0];
                  next_s.temp  = s.tmr[sel].count[15:8];
               end
               REG_CMPA_L: begin
                  next_s.rdata = s.tmr[sel].cmp_a[7:0];
                  next_s.temp  = s.tmr[sel].cmp_a[15:8];
               end
               REG_CMPB_L: begin
                  next_s.rdata = s.tmr[sel].cmp_b[7:0];
                  next_s.temp  = s.tmr[sel].cmp_b[15:8];
               end
               REG_CAP_L: begin
                  next_s.rdata = s.tmr[sel].cap[7:0];
                  next_s.temp  = s.tmr[sel].cap[15:8];
               end
               REG_CNT_H, REG_CMPA_H, REG_CMPB_H, REG_CAP_H: next_s.rdata = s.temp;
               default: next_s.rdata = '0;
            endcase
         end
      end
   end

   // ---------------------------------------------------------------
   // state register
   // ---------------------------------------------------------------
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   assign io_rdata = s.rdata;
   assign events   = s.ev;

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   default clocking @(posedge clk); endclocking
   default disable iff (!rstn);

   capture_copy_a: assert property (
      cap_event[0] && !io_wr |=> s.tmr[0].cap == $past(s.tmr[0].count))
      else $error("capture value is not the count at the trigger");

   capture_flag_a: assert property (cap_event[1] |=> events[1].capture_flag_set)
      else $error("capture trigger without flag pulse");

   capture_off_a: assert property (
      cap_is_top(mode_of(s.tmr[0].ctrl, waveform_mode_lower[0])) && !io_wr
      |=> s.tmr[0].cap == $past(s.tmr[0].cap))
      else $error("capture happened while capture value is top");

   reserved_zero_a: assert property (!s.tmr[0].ctrl[5] && !s.tmr[1].ctrl[5])
      else $error("reserved control bit reads one");

   div8_spacing_a: assert property (
      (s.tmr[0].ctrl[CS_MSB:0] == CS_DIV8 && tick[0]) ##1
      (s.tmr[0].ctrl[CS_MSB:0] == CS_DIV8 && !tick[0]) [*7]
      |=> tick[0] || s.tmr[0].ctrl[CS_MSB:0] != CS_DIV8)
      else $error("divide-by-8 tick spacing wrong");

   stopped_a: assert property (
      s.tmr[1].ctrl[CS_MSB:0] == CS_STOP && !io_wr |=> $stable(s.tmr[1].count))
      else $error("stopped counter moved");

   pin_rise_a: assert property (
      s.tmr[0].ctrl[CS_MSB:0] == CS_ALT_HI && $rose(s.ext_s2) |-> tick[0])
      else $error("rising count pin edge did not tick");

   div16_spacing_a: assert property (
      tick[1] && s.tmr[1].ctrl[CS_MSB:0] == CS_ALT_LO
      && $past(s.tmr[1].ctrl[CS_MSB:0], 16) == CS_ALT_LO |-> $past(tick[1], 16))
      else $error("second timer divide-by-16 spacing wrong");

   sequence cmpa_hi_wr;
      io_wr && io_addr == {BLOCK_BASE, 1'b0, REG_CMPA_H};
   endsequence
   sequence cmpa_lo_wr;
      io_wr && io_addr == {BLOCK_BASE, 1'b0, REG_CMPA_L};
   endsequence

   pair_write_a: assert property (
      cmpa_hi_wr ##1 (!io_wr && !io_rd) ##1 cmpa_lo_wr
      |=> s.tmr[0].cmp_a == {$past(io_wdata, 3), $past(io_wdata)})
      else $error("16-bit write did not commit both bytes");

   match_block_a: assert property (
      tick[0] && s.tmr[0].block |=> !events[0].match_a && !events[0].match_b)
      else $error("match reported on blocked tick");

   match_seen_a: assert property (
      tick[1] && !s.tmr[1].block && s.tmr[1].count == s.tmr[1].cmp_a
      |=> events[1].match_a)
      else $error("compare match missed");

   top_flag_a: assert property (
      tick[0] && cap_is_top(mode_of(s.tmr[0].ctrl, waveform_mode_lower[0]))
      && s.tmr[0].count == s.tmr[0].cap && !io_wr
      |=> events[0].capture_flag_set && s.tmr[0].count == 16'h0000)
      else $error("capture-top reach did not flag and wrap");

endmodule // timer16_capture_compare_ctrl

// ---- sim/cpu_model.sv ----
// byte-wide cpu model issuing register reads and writes on the timer i/o port
// assumes the design takes a strobe at the rising edge and answers one cycle later
module cpu_model
   import timer_pkg::*;
(
   input  wire logic       clk,      // i/o clock
   input  wire logic [7:0] io_rdata, // read byte
   output logic      [7:0] io_addr,  // register index
   output logic      [7:0] io_wdata, // write byte
   output logic            io_wr,    // write strobe
   output logic            io_rd     // read strobe
);
   timeunit 1ns;
   timeprecision 1ns;
   initial begin
      io_addr = 8'h00;
      io_wdata = 8'h00;
      io_wr = 1'b0;
      io_rd = 1'b0;
   end
   // one byte write; released data shows the inverse so stale bytes never look valid
   task automatic wr8(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk);
      io_addr = a;
      io_wdata = d;
      io_wr = 1'b1;
      @(negedge clk);
      io_wr = 1'b0;
      io_wdata = ~d;
   endtask
   task automatic rd8(input logic [7:0] a, output logic [7:0] d);
      @(negedge clk);
      io_addr = a;
      io_rd = 1'b1;
      @(negedge clk);
      io_rd = 1'b0;
      d = io_rdata;
   endtask
   // high byte lands in the shared latch, low byte commits the pair
   task automatic wr16(input logic [7:0] lo_a, input logic [15:0] v);
      wr8(lo_a + 8'h01, v[15:8]);
      wr8(lo_a, v[7:0]);
   endtask
   task automatic rd16(input logic [7:0] lo_a, output logic [15:0] v);
      rd8(lo_a, v[7:0]);
      rd8(lo_a + 8'h01, v[15:8]);
   endtask
   // reserved bit always written as zero
   task automatic wr_ctrl(input logic [7:0] a, input logic [7:0] d);
      wr8(a, d & CTRL_WMASK);
   endtask
endmodule // cpu_model

// ---- sim/tb_timer16_capture_compare_ctrl.sv ----
// self-checking bench for the dual capture/compare timer
// assumes cpu_model on the i/o port; pins driven here at the falling edge
module tb_timer16_capture_compare_ctrl;
   import timer_pkg::*;
   timeunit 1ns;
   timeprecision 1ns;
   logic            clk = 1'b0;
   logic            rstn = 1'b0;
   logic [7:0]      io_addr, io_wdata, io_rdata;
   logic            io_wr, io_rd;
   logic [1:0]      cap_pin = 2'b00;
   logic            ext_pin = 1'b0;
   logic [1:0][1:0] wml = '0;
   events_t [1:0]   events;
   int              fail_count = 0;
   int              n_compared = 0;
   logic [15:0]     v;
   logic [7:0]      b;
   int              n, n0;
   int              dv [8] = '{0, 1, 8, 64, 256, 1024, 16, 32};
   always #50 clk = ~clk;
   cpu_model i_cpu (.clk(clk), .io_rdata(io_rdata), .io_addr(io_addr),
      .io_wdata(io_wdata), .io_wr(io_wr), .io_rd(io_rd));
   timer16_capture_compare_ctrl i_dut (.clk(clk), .rstn(rstn), .io_addr(io_addr),
      .io_wdata(io_wdata), .io_wr(io_wr), .io_rd(io_rd), .io_rdata(io_rdata),
      .capture_input_pin(cap_pin), .external_count_pin(ext_pin),
      .waveform_mode_lower(wml), .events(events));
   // ---------------------------------------------------------------
   // helpers
   // ---------------------------------------------------------------
   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      n_compared++;
      if (seen !== exp) begin
         fail_count++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask
   function automatic logic [7:0] ra(input logic t, input logic [3:0] off);
      return {3'h0, t, off};
   endfunction
   // counts falling edges until the event bit shows, bounded by lim
   task automatic wait_ev(input logic t, input int e, input int lim, output int k);
      k = 0;
      do begin
         @(negedge clk);
         k++;
      end while (events[t][e] !== 1'b1 && k < lim);
   endtask
   task automatic wrap_up();
      $display("compared %0d mismatches %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   // ---------------------------------------------------------------
   // scenarios
   // ---------------------------------------------------------------
   task automatic t_regs();
      for (int t = 0; t < 2; t++) begin
         for (int o = 0; o < 9; o++) begin
            i_cpu.rd8(ra(t[0], o[3:0]), b);
            check("reset value", {8'h00, b}, 16'h0000);
         end
      end
      i_cpu.wr8(8'h19, 8'h55);
      i_cpu.rd8(8'h19, b);
      check("unmapped", {8'h00, b}, 16'h0000);
      i_cpu.wr8(ra(0, REG_CTRL_B), 8'h20);
      i_cpu.rd8(ra(0, REG_CTRL_B), b);
      check("reserved bit", {8'h00, b}, 16'h0000);
      i_cpu.wr16(ra(0, REG_CMPA_L), 16'h1234);
      i_cpu.wr16(ra(1, REG_CMPB_L), 16'hBEEF);
      i_cpu.wr8(ra(0, REG_CMPA_H), 8'h77);
      i_cpu.rd16(ra(0, REG_CMPA_L), v);
      check("lone high write", v, 16'h1234);
      i_cpu.rd8(ra(1, REG_CMPB_L), b);
      i_cpu.rd8(ra(0, REG_CMPB_H), b);
      check("shared latch", {8'h00, b}, 16'h00BE);
   endtask
   // compare-a as top with value 1: two ticks between top pulses
   task automatic t_divide();
      for (int t = 0; t < 2; t++) begin
         for (int cs = 1; cs < (t ? 8 : 6); cs++) begin
            i_cpu.wr_ctrl(ra(t[0], REG_CTRL_B), 8'h00);
            i_cpu.wr16(ra(t[0], REG_CNT_L), 16'h0000);
            i_cpu.wr16(ra(t[0], REG_CMPA_L), 16'h0001);
            i_cpu.wr_ctrl(ra(t[0], REG_CTRL_B), {3'b000, 2'b01, cs[2:0]});
            wait_ev(t[0], 0, 5000, n);
            wait_ev(t[0], 0, 5000, n);
            check("top period", n[15:0], 16'(2 * dv[cs]));
            check("match at top", {15'h0, events[t].match_a}, 16'h0001);
         end
         i_cpu.wr_ctrl(ra(t[0], REG_CTRL_B), 8'h00);
      end
   endtask
   // five rising and four falling pin edges tell the two pin codes apart
   task automatic t_pin();
      for (int cs = 6; cs < 8; cs++) begin
         i_cpu.wr_ctrl(ra(0, REG_CTRL_B), 8'h00);
         ext_pin = 1'b0;
         i_cpu.wr16(ra(0, REG_CNT_L), 16'h0000);
         i_cpu.wr_ctrl(ra(0, REG_CTRL_B), cs[7:0]);
         for (int i = 0; i < 5; i++) begin
            ext_pin = 1'b1;
            repeat (3) @(negedge clk);
            if (i < 4) ext_pin = 1'b0;
            repeat (3) @(negedge clk);
         end
         i_cpu.rd16(ra(0, REG_CNT_L), v);
         check("pin count", v, (cs == 7) ? 16'h0005 : 16'h0004);
      end
      i_cpu.wr_ctrl(ra(0, REG_CTRL_B), 8'h00);
   endtask
   // counter stopped so the captured value is known
   task automatic cap_lat(input logic t, input logic filt, input logic rise, output int k);
      cap_pin[t] = ~rise;
      i_cpu.wr16(ra(t, REG_CNT_L), {14'h0280, filt, rise});
      i_cpu.wr_ctrl(ra(t, REG_CTRL_B), {filt, rise, 6'h00});
      repeat (10) @(negedge clk);
      cap_pin[t] = rise;
      wait_ev(t, 3, 40, k);
      check("capture flag", {15'h0, events[t].capture_flag_set}, 16'h0001);
      i_cpu.rd16(ra(t, REG_CAP_L), v);
      check("capture value", v, {14'h0280, filt, rise});
      cap_pin[t] = ~rise;
      wait_ev(t, 3, 16, n);
      check("wrong edge", {15'h0, events[t][3]}, 16'h0000);
   endtask
   task automatic t_capture();
      for (int t = 0; t < 2; t++) begin
         for (int e = 0; e < 2; e++) begin
            cap_lat(t[0], 1'b0, e[0], n0);
            cap_lat(t[0], 1'b1, e[0], n);
            check("filter delay", 16'(n - n0), 16'h0004);
         end
      end
      // three-sample glitch must not pass the filter
      cap_pin[0] = 1'b1;
      repeat (3) @(negedge clk);
      cap_pin[0] = 1'b0;
      wait_ev(0, 3, 20, n);
      check("glitch", {15'h0, events[0][3]}, 16'h0000);
      // mode 12 uses the capture register as top: pin is disconnected
      i_cpu.wr_ctrl(ra(0, REG_CTRL_B), 8'h58);
      cap_pin[0] = 1'b1;
      wait_ev(0, 3, 20, n);
      check("capture off", {15'h0, events[0][3]}, 16'h0000);
      cap_pin[0] = 1'b0;
      i_cpu.wr_ctrl(ra(0, REG_CTRL_B), 8'h00);
   endtask
   // count written while running: deliberate, to see the next match dropped
   task automatic t_block();
      i_cpu.wr16(ra(0, REG_CNT_L), 16'h0100);
      i_cpu.wr16(ra(0, REG_CMPA_L), 16'h0105);
      i_cpu.wr_ctrl(ra(0, REG_CTRL_B), 8'h01);
      wait_ev(0, 2, 20, n);
      check("match seen", {15'h0, events[0].match_a}, 16'h0001);
      i_cpu.wr16(ra(0, REG_CNT_L), 16'h0105);
      wait_ev(0, 2, 8, n);
      check("match blocked", {15'h0, events[0].match_a}, 16'h0000);
      i_cpu.wr_ctrl(ra(0, REG_CTRL_B), 8'h00);
   endtask
   // ---------------------------------------------------------------
   // main sequence and watchdog
   // ---------------------------------------------------------------
   initial begin
      repeat (4) @(negedge clk);
      rstn = 1'b1;
      t_regs();
      t_divide();
      t_pin();
      t_capture();
      t_block();
      wrap_up();
   end
   // budget well above the longest divide run
   initial begin
      #4000000;
      fail_count++;
      wrap_up();
   end
endmodule // tb_timer16_capture_compare_ctrl
